// ==== verilog/crt_pkg.sv ====
// constants, types and instruction classes for the reset and cycle timing block
// assumes a single 10 MHz reference clock and an active-high asynchronous reset
// Summary of operation
// RULE_01: held in reset while reset input is low
// RULE_02: reset source waits for stable supply, clock
// RULE_03: reset source asserts reset through power-up
// RULE_04: reset aborts any bus cycle at once
// RULE_05: lock, strap, upper address become pulled-up inputs
// RULE_06: only strap may pull low; selects emulation
// RULE_07: add-with-carry immediate to accumulator: 1 clock
// RULE_08: or immediate to accumulator: 1 clock
// RULE_09: bounds check 20/40 or 24/64 clocks
// RULE_10: direct jumps 3, relative jumps 4 clocks
// RULE_11: conditional jump 3/5, count-zero jump 3/4
// RULE_12: loop falls through 3, branches 4 clocks
// RULE_13: store accumulator direct: 5 or 8/12
// RULE_14: load accumulator direct: 5 or 8/12
// RULE_15: immediate to general register: 1 clock
// RULE_16: register move 2, memory destination 5/20
// RULE_17: segment load register 2, memory 5/20
// RULE_18: near return with pop adjust 16/13
// RULE_19: rotate left by one 1, memory 8/16
// RULE_20: rotate right by count 1, memory 8/16
// RULE_21: build parameter selects bus-width variant counts
// RULE_22: first count register/untaken, second memory/taken
package crt_pkg;

  // bus-width variant selectors
  localparam logic VARIANT_WIDE = 1'b0; // 16-bit external bus
  localparam logic VARIANT_NARROW = 1'b1; // 8-bit external bus

  localparam int CNT_W = 7; // width of the clock counter
  localparam int BUS_CYCLE_LEN = 4; // length of a generic bus cycle in clocks

  // instruction classes
  typedef enum logic [3:0] {
    CRT_OP_ADC_ACC = 4'h0,
    CRT_OP_OR_ACC = 4'h1,
    CRT_OP_BOUND = 4'h2,
    CRT_OP_JMP_DIRECT = 4'h3,
    CRT_OP_JMP_REL = 4'h4,
    CRT_OP_JCC = 4'h5,
    CRT_OP_JCXZ = 4'h6,
    CRT_OP_LOOP = 4'h7,
    CRT_OP_STORE_ACC = 4'h8,
    CRT_OP_LOAD_ACC = 4'h9,
    CRT_OP_MOV_IMM_REG = 4'hA,
    CRT_OP_MOV_REG_RM = 4'hB,
    CRT_OP_MOV_SEG = 4'hC,
    CRT_OP_RET_NEAR_IMM = 4'hD,
    CRT_OP_ROL_1 = 4'hE,
    CRT_OP_ROR_CL = 4'hF
  } crt_op_type;

  // one issued instruction
  typedef struct packed {
    crt_op_type op; // instruction class
    logic alt; // memory operand or taken case
    logic word; // word data for accumulator moves
  } crt_instr_type;

  // pull-up pin group: lock, strap, upper address
  typedef struct packed {
    logic lock; // bus lock pin
    logic strap; // addr19 emulation strap
    logic [2:0] upper; // upper_address_pins 18..16
  } crt_pins_type;

  localparam crt_pins_type PINS_RESET = 5'h00; // outputs not driven
  localparam crt_pins_type PINS_IDLE_OE = 5'h1F; // all driven when running
  localparam logic [CNT_W-1:0] CNT_RESET = 7'h00; // counter reset value

  // clock counts, wide variant
  localparam logic [CNT_W-1:0] W_ONE = 7'h01;
  localparam logic [CNT_W-1:0] W_BOUND_OK = 7'h14;
  localparam logic [CNT_W-1:0] W_BOUND_INT = 7'h28;
  localparam logic [CNT_W-1:0] W_JMP_DIRECT = 7'h03;
  localparam logic [CNT_W-1:0] W_JMP_REL = 7'h04;
  localparam logic [CNT_W-1:0] W_JCC_NT = 7'h03;
  localparam logic [CNT_W-1:0] W_JCC_T = 7'h05;
  localparam logic [CNT_W-1:0] W_JCXZ_NT = 7'h03;
  localparam logic [CNT_W-1:0] W_JCXZ_T = 7'h04;
  localparam logic [CNT_W-1:0] W_LOOP_NT = 7'h03;
  localparam logic [CNT_W-1:0] W_LOOP_T = 7'h04;
  localparam logic [CNT_W-1:0] W_ACC_MEM = 7'h05;
  localparam logic [CNT_W-1:0] W_MOV_REG = 7'h02;
  localparam logic [CNT_W-1:0] W_MOV_MEM = 7'h05;
  localparam logic [CNT_W-1:0] W_RET_IMM = 7'h10;
  localparam logic [CNT_W-1:0] W_ROT_MEM = 7'h08;

  // clock counts, narrow variant
  localparam logic [CNT_W-1:0] N_BOUND_OK = 7'h18;
  localparam logic [CNT_W-1:0] N_BOUND_INT = 7'h40;
  localparam logic [CNT_W-1:0] N_ACC_BYTE = 7'h08;
  localparam logic [CNT_W-1:0] N_ACC_WORD = 7'h0C;
  localparam logic [CNT_W-1:0] N_MOV_MEM = 7'h14;
  localparam logic [CNT_W-1:0] N_RET_IMM = 7'h0D;
  localparam logic [CNT_W-1:0] N_ROT_MEM = 7'h10;

endpackage

// ==== verilog/crt_cycle_table.sv ====
// lookup of the clock count for one instruction class
// assumes the variant is fixed at build time
`timescale 1ns/1ns
module crt_cycle_table
  import crt_pkg::*;
#(
  parameter logic VARIANT = VARIANT_WIDE // bus-width variant
) (
  input wire crt_instr_type i_instr, // instruction to cost
  output logic [CNT_W-1:0] o_clocks // clocks the instruction takes
);

  // pick first or second figure of a pair
  function automatic logic [CNT_W-1:0] pick(input logic alt,
                                             input logic [CNT_W-1:0] a,
                                             input logic [CNT_W-1:0] b);
    pick = alt ? b : a; // [RULE_22]
  endfunction

  localparam logic NARROW = (VARIANT == VARIANT_NARROW); // [RULE_21]

  // count decode per class
  always_comb begin
    unique case (i_instr.op)
      CRT_OP_ADC_ACC: o_clocks = W_ONE; // [RULE_07]
      CRT_OP_OR_ACC: o_clocks = W_ONE; // [RULE_08]
      CRT_OP_BOUND: begin
        o_clocks = NARROW ? pick(i_instr.alt, N_BOUND_OK, N_BOUND_INT)
                          : pick(i_instr.alt, W_BOUND_OK, W_BOUND_INT); // [RULE_09]
      end
      CRT_OP_JMP_DIRECT: o_clocks = W_JMP_DIRECT; // [RULE_10]
      CRT_OP_JMP_REL: o_clocks = W_JMP_REL; // [RULE_10]
      CRT_OP_JCC: o_clocks = pick(i_instr.alt, W_JCC_NT, W_JCC_T); // [RULE_11]
      CRT_OP_JCXZ: o_clocks = pick(i_instr.alt, W_JCXZ_NT, W_JCXZ_T); // [RULE_11]
      CRT_OP_LOOP: o_clocks = pick(i_instr.alt, W_LOOP_NT, W_LOOP_T); // [RULE_12]
      CRT_OP_STORE_ACC, CRT_OP_LOAD_ACC: begin
        // [RULE_13] [RULE_14]
        o_clocks = NARROW ? pick(i_instr.word, N_ACC_BYTE, N_ACC_WORD) : W_ACC_MEM;
      end
      CRT_OP_MOV_IMM_REG: o_clocks = W_ONE; // [RULE_15]
      CRT_OP_MOV_REG_RM, CRT_OP_MOV_SEG: begin
        // [RULE_16] [RULE_17]
        o_clocks = pick(i_instr.alt, W_MOV_REG, NARROW ? N_MOV_MEM : W_MOV_MEM);
      end
      CRT_OP_RET_NEAR_IMM: o_clocks = NARROW ? N_RET_IMM : W_RET_IMM; // [RULE_18]
      CRT_OP_ROL_1, CRT_OP_ROR_CL: begin
        // [RULE_19] [RULE_20]
        o_clocks = pick(i_instr.alt, W_ONE, NARROW ? N_ROT_MEM : W_ROT_MEM);
      end
    endcase
  end

endmodule

// ==== verilog/crt_strap_pins.sv ====
// pull-up pin group handling and emulation strap capture
// assumes pin inputs are synchronous to the reference clock
`timescale 1ns/1ns
module crt_strap_pins
  import crt_pkg::*;
(
  input wire logic i_ref_clk, // reference clock
  input wire logic i_rst, // asynchronous reset, active high
  input wire logic i_in_reset, // core held in reset
  input wire crt_pins_type i_pins_in, // pin levels seen
  output crt_pins_type o_pins_oe, // pin output enables
  output logic o_emulation_mode // emulation mode selected
);

  // release pins to pull-ups during reset, drive otherwise
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pins_oe <= PINS_RESET;
    end else if (i_in_reset) begin
      o_pins_oe <= PINS_RESET; // [RULE_05]
    end else begin
      o_pins_oe <= PINS_IDLE_OE;
    end
  end

  // sample strap while reset stands, other pins ignored
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_emulation_mode <= 1'b0;
    end else if (i_in_reset) begin
      o_emulation_mode <= ~i_pins_in.strap; // [RULE_06]
    end
  end

endmodule

// ==== verilog/crt_core_timing.sv ====
// reset entry and instruction cycle sequencer
// assumes an external circuit holds reset through power-up and clock start
`timescale 1ns/1ns
module crt_core_timing
  import crt_pkg::*;
#(
  parameter logic VARIANT = VARIANT_WIDE // bus-width variant
) (
  input wire logic i_ref_clk, // reference clock
  input wire logic i_rst, // asynchronous reset, active high
  input wire logic i_reset_in_n, // external reset input, active low
  input wire logic i_issue, // issue request pulse
  input wire crt_instr_type i_instr, // instruction to issue
  input wire logic i_bus_start, // start a bus cycle
  input wire crt_pins_type i_pins_in, // levels on pull-up pin group
  output crt_pins_type o_pins_out, // levels driven on pin group
  output crt_pins_type o_pins_oe, // output enables of pin group
  output logic o_in_reset, // core in reset state
  output logic o_emulation_mode, // emulation mode strap result
  output logic o_busy, // instruction executing
  output logic o_ready, // ready for next instruction
  output logic o_done, // instruction finished pulse
  output logic o_bus_active, // bus cycle in progress
  output logic o_bus_aborted // bus cycle cut short pulse
);

  // sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_IDLE = 3'b010,
    ST_EXEC = 3'b100
  } crt_state_type;

  crt_state_type state_reg; // current state
  crt_state_type state_next; // next state
  logic [CNT_W-1:0] cnt_reg; // clocks left in instruction
  logic [CNT_W-1:0] clocks; // looked-up count
  logic [2:0] bus_cnt_reg; // clocks left in bus cycle
  crt_pins_type pins_oe; // enables from pin block
  logic emul; // strap result from pin block
  logic reset_req; // reset input asserted

  assign reset_req = ~i_reset_in_n; // [RULE_01]

  // cost lookup
  crt_cycle_table #(
    .VARIANT(VARIANT)
  ) u_table (
    .i_instr(i_instr),
    .o_clocks(clocks)
  );

  // pin group and strap
  crt_strap_pins u_pins (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_reset(reset_req),
    .i_pins_in(i_pins_in),
    .o_pins_oe(pins_oe),
    .o_emulation_mode(emul)
  );

  // next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RESET: state_next = ST_IDLE;
      ST_IDLE: begin
        if (i_issue) begin
          state_next = (clocks == W_ONE) ? ST_IDLE : ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (cnt_reg == W_ONE) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_RESET;
    endcase
    if (reset_req) begin
      state_next = ST_RESET; // [RULE_01]
    end
  end

  // state register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // clock countdown
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= CNT_RESET;
    end else if (reset_req) begin
      cnt_reg <= CNT_RESET;
    end else if (state_reg == ST_IDLE && i_issue) begin
      cnt_reg <= clocks - W_ONE; // first clock spent on issue
    end else if (state_reg == ST_EXEC) begin
      cnt_reg <= cnt_reg - W_ONE;
    end
  end

  // status flags
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_in_reset <= 1'b1;
      o_busy <= 1'b0;
      o_ready <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_in_reset <= state_next == ST_RESET;
      o_busy <= state_next == ST_EXEC;
      o_ready <= state_next == ST_IDLE;
      o_done <= ~reset_req && ((state_reg == ST_IDLE && i_issue && clocks == W_ONE)
                || (state_reg == ST_EXEC && cnt_reg == W_ONE));
    end
  end

  // bus cycle tracker, cut short by reset
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bus_cnt_reg <= 3'h0;
      o_bus_active <= 1'b0;
      o_bus_aborted <= 1'b0;
    end else if (reset_req) begin
      bus_cnt_reg <= 3'h0; // [RULE_04]
      o_bus_active <= 1'b0; // [RULE_04]
      o_bus_aborted <= o_bus_active; // [RULE_04]
    end else begin
      o_bus_aborted <= 1'b0;
      if (!o_bus_active && i_bus_start && state_reg != ST_RESET) begin
        bus_cnt_reg <= 3'(BUS_CYCLE_LEN - 1);
        o_bus_active <= 1'b1;
      end else if (o_bus_active) begin
        bus_cnt_reg <= bus_cnt_reg - 3'h1;
        o_bus_active <= bus_cnt_reg != 3'h0;
      end
    end
  end

  // pin drive levels: high when driven, released in reset
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pins_out <= PINS_RESET;
      o_pins_oe <= PINS_RESET;
      o_emulation_mode <= 1'b0;
    end else begin
      o_pins_out <= pins_oe; // [RULE_05]
      o_pins_oe <= pins_oe;
      o_emulation_mode <= emul;
    end
  end

endmodule

// ==== dv/crt_core_timing_properties.sv ====
// concurrent checks on the reset and cycle timing sequencer ports
// assumes one clock domain and the async reset i_rst; bound below
`timescale 1ns/1ns
module crt_core_timing_properties
  import crt_pkg::*;
#(
  parameter logic VARIANT = VARIANT_WIDE // bus-width variant
) (
  input wire logic i_ref_clk, // reference clock
  input wire logic i_rst, // async reset, high
  input wire logic i_reset_in_n, // external reset, low
  input wire logic i_issue, // issue pulse
  input wire crt_instr_type i_instr, // issued instruction
  input wire logic i_bus_start, // bus cycle start
  input wire crt_pins_type i_pins_in, // pin levels seen
  input wire crt_pins_type o_pins_out, // pin drive levels
  input wire crt_pins_type o_pins_oe, // pin enables
  input wire logic o_in_reset, // reset state
  input wire logic o_emulation_mode, // emulation mode
  input wire logic o_busy, // executing
  input wire logic o_ready, // idle
  input wire logic o_done, // end pulse
  input wire logic o_bus_active, // bus cycle running
  input wire logic o_bus_aborted // abort pulse
);
  // clock counts of the selected variant
  localparam int BND_N = (VARIANT == VARIANT_NARROW) ? 24 : 20;
  localparam int STW_N = (VARIANT == VARIANT_NARROW) ? 12 : 5;
  localparam int RET_N = (VARIANT == VARIANT_NARROW) ? 13 : 16;
  localparam int ROT_N = (VARIANT == VARIANT_NARROW) ? 16 : 8;
  logic take; // instruction accepted at this edge
  logic one; // single-clock class
  assign take = o_ready && i_issue && i_reset_in_n;
  assign one = (i_instr.op inside {CRT_OP_ADC_ACC, CRT_OP_OR_ACC, CRT_OP_MOV_IMM_REG})
    || ((i_instr.op inside {CRT_OP_ROL_1, CRT_OP_ROR_CL}) && !i_instr.alt);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  a_reset_holds: assert property (
    !i_reset_in_n |=> o_in_reset && !o_busy && !o_ready)
    else $error("core not held in reset");
  a_bus_abort: assert property (
    o_bus_active && !i_reset_in_n |=> o_bus_aborted && !o_bus_active)
    else $error("bus cycle not cut by reset");
  a_pins_release: assert property (
    !i_reset_in_n [*4] |-> o_pins_oe == PINS_RESET)
    else $error("pin group still driven in reset");
  a_strap_hold: assert property (
    !o_in_reset && !$past(o_in_reset) |-> $stable(o_emulation_mode))
    else $error("emulation mode moved while running");
  a_one_clock: assert property (
    take && one |=> o_done)
    else $error("single-clock class not done in one clock");
  a_jcc_taken: assert property (
    take && i_instr.op == CRT_OP_JCC && i_instr.alt |=> !o_done [*4] ##1 o_done)
    else $error("taken branch not five clocks");
  a_bound_ok: assert property (
    take && i_instr.op == CRT_OP_BOUND && !i_instr.alt |-> ##BND_N o_done)
    else $error("bounds check count wrong");
  a_store_word: assert property (
    take && i_instr.op == CRT_OP_STORE_ACC && i_instr.word |-> ##STW_N o_done)
    else $error("word store count wrong");
  a_ret_adjust: assert property (
    take && i_instr.op == CRT_OP_RET_NEAR_IMM |-> ##RET_N o_done)
    else $error("near return count wrong");
  a_rot_memory: assert property (
    take && i_instr.op == CRT_OP_ROR_CL && i_instr.alt |-> ##ROT_N o_done)
    else $error("memory rotate count wrong");
  // main scenarios reached
  c_bound_int: cover property (take && i_instr.op == CRT_OP_BOUND && i_instr.alt);
  c_abort: cover property (o_bus_aborted);
  c_emulation: cover property (o_emulation_mode && !o_in_reset);
endmodule

bind crt_core_timing crt_core_timing_properties #(.VARIANT(VARIANT)) u_props (
  .i_ref_clk, .i_rst, .i_reset_in_n, .i_issue, .i_instr, .i_bus_start, .i_pins_in,
  .o_pins_out, .o_pins_oe, .o_in_reset, .o_emulation_mode, .o_busy, .o_ready,
  .o_done, .o_bus_active, .o_bus_aborted
);

// ==== dv/crt_reset_source.sv ====
// behavioural board model: reset circuit, pull-ups and emulation strap
// assumes the bench asks for reset release through i_run
`timescale 1ns/1ns
module crt_reset_source
  import crt_pkg::*;
#(
  parameter int PWRUP_CYC = 15 // settling clocks, plain default
) (
  input wire logic i_ref_clk, // reference clock
  input wire logic i_run, // bench asks to leave reset
  input wire logic i_strap_low, // emulation strap fitted
  input wire crt_pins_type i_pins_out, // device drive levels
  input wire crt_pins_type i_pins_oe, // device enables
  output logic o_reset_in_n, // reset to device, low active
  output crt_pins_type o_pins_in // resolved pin levels
);
  int cnt_reg = 0; // clocks since power-up
  logic hold_reg = 1'h0; // strap hold after release
  logic strap_lvl; // weak strap level
  // count settling of supply and clock
  always @(posedge i_ref_clk) begin
    if (cnt_reg < PWRUP_CYC) begin
      cnt_reg <= cnt_reg + 1;
    end
    hold_reg <= o_reset_in_n;
  end
  // reset held through power-up until settled
  assign o_reset_in_n = i_run && (cnt_reg >= PWRUP_CYC);
  // only the strap is pulled low, in reset and one clock after
  assign strap_lvl = ~(i_strap_low && !(o_reset_in_n && hold_reg));
  // a driving device wins over the weak pull-ups
  assign o_pins_in = (i_pins_oe & i_pins_out)
    | (~i_pins_oe & {1'h1, strap_lvl, 3'h7});
endmodule

// ==== dv/crt_core_timing_tb.sv ====
// self-checking bench: both bus-width variants side by side
// assumes the board model drives reset and resolves the pin group
`timescale 1ns/1ns
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got); end end
module crt_core_timing_tb;
  import crt_pkg::*;
  logic clk = 1'h0; // reference clock
  logic rst = 1'h1; // async reset
  logic run = 1'h0; // leave-reset request
  logic strap_low = 1'h0; // strap fitted
  logic issue = 1'h0; // issue pulse
  logic bus_start = 1'h0; // bus cycle start
  crt_instr_type instr = '0; // instruction
  logic reset_n; // reset from board model
  crt_pins_type pins_in, pins_out, pins_oe; // pin group
  logic in_rst, emu, ready, done, bus_act, aborted, done_n, busy; // observed outputs
  int fail_count = 0; // mismatches
  int tests_run = 0; // comparisons
  int cycles = 0; // timeout counter
  always #50 clk = ~clk;
  crt_reset_source u_src (.i_ref_clk(clk), .i_run(run), .i_strap_low(strap_low),
    .i_pins_out(pins_out), .i_pins_oe(pins_oe), .o_reset_in_n(reset_n), .o_pins_in(pins_in));
  crt_core_timing #(.VARIANT(VARIANT_WIDE)) u_dut (.i_ref_clk(clk), .i_rst(rst),
    .i_reset_in_n(reset_n), .i_issue(issue), .i_instr(instr), .i_bus_start(bus_start),
    .i_pins_in(pins_in), .o_pins_out(pins_out), .o_pins_oe(pins_oe), .o_in_reset(in_rst),
    .o_emulation_mode(emu), .o_busy(busy), .o_ready(ready), .o_done(done),
    .o_bus_active(bus_act), .o_bus_aborted(aborted));
  crt_core_timing #(.VARIANT(VARIANT_NARROW)) u_dut_narrow (.i_ref_clk(clk), .i_rst(rst),
    .i_reset_in_n(reset_n), .i_issue(issue), .i_instr(instr), .i_bus_start(bus_start),
    .i_pins_in(pins_in), .o_pins_out(), .o_pins_oe(), .o_in_reset(), .o_emulation_mode(),
    .o_busy(), .o_ready(), .o_done(done_n), .o_bus_active(), .o_bus_aborted());
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  // bounded wait for the core to accept work
  task automatic wait_ready();
    for (int k = 0; k < 40 && ready !== 1'h1; k++) @(negedge clk);
    `CHK("ready after release", 1'h1, ready)
  endtask
  // issue one instruction to both variants and count clocks to done
  task automatic run_op(input crt_op_type op, input logic alt, input logic word,
                        input int exp_w, input int exp_n);
    int got_w = 0;
    int got_n = 0;
    @(negedge clk);
    instr = '{op, alt, word};
    issue = 1'h1;
    @(negedge clk);
    issue = 1'h0;
    // multi-clock classes show busy right after the take edge
    `CHK("busy after issue", exp_w > 1, busy)
    for (int k = 1; k <= 70 && (got_w == 0 || got_n == 0); k++) begin
      if (got_w == 0 && done === 1'h1) got_w = k;
      if (got_n == 0 && done_n === 1'h1) got_n = k;
      @(negedge clk);
    end
    `CHK("wide clocks", exp_w, got_w)
    `CHK("narrow clocks", exp_n, got_n)
  endtask
  // power-up reset state, then release
  task automatic t_power_up();
    repeat (4) @(negedge clk);
    `CHK("in reset", 1'h1, in_rst)
    `CHK("pin enables", 5'h00, pins_oe)
    `CHK("pin drive", 5'h00, pins_out)
    run = 1'h1;
    wait_ready();
    `CHK("emulation off", 1'h0, emu)
    // enables and drive levels return two clocks after release
    @(negedge clk);
    `CHK("pin enables run", 5'h1F, pins_oe)
    `CHK("pin drive run", 5'h1F, pins_out)
  endtask
  // warm reset in mid bus cycle, with or without the strap
  task automatic t_warm(input logic strap);
    @(negedge clk);
    bus_start = 1'h1;
    @(negedge clk);
    bus_start = 1'h0;
    strap_low = strap;
    run = 1'h0;
    @(negedge clk);
    `CHK("abort pulse", 1'h1, aborted)
    `CHK("bus active", 1'h0, bus_act)
    `CHK("in reset", 1'h1, in_rst)
    repeat (4) @(negedge clk);
    `CHK("strap level", ~strap, pins_in.strap)
    `CHK("pin enables", 5'h00, pins_oe)
    run = 1'h1;
    wait_ready();
    strap_low = 1'h0;
    `CHK("emulation mode", strap, emu)
  endtask
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'h0;
    t_power_up();
    run_op(CRT_OP_ADC_ACC, 1'h0, 1'h0, 1, 1);
    run_op(CRT_OP_OR_ACC, 1'h0, 1'h0, 1, 1);
    run_op(CRT_OP_BOUND, 1'h0, 1'h0, 20, 24);
    run_op(CRT_OP_BOUND, 1'h1, 1'h0, 40, 64);
    run_op(CRT_OP_JMP_DIRECT, 1'h0, 1'h0, 3, 3);
    run_op(CRT_OP_JMP_REL, 1'h0, 1'h0, 4, 4);
    run_op(CRT_OP_JCC, 1'h0, 1'h0, 3, 3);
    run_op(CRT_OP_JCC, 1'h1, 1'h0, 5, 5);
    run_op(CRT_OP_JCXZ, 1'h0, 1'h0, 3, 3);
    run_op(CRT_OP_JCXZ, 1'h1, 1'h0, 4, 4);
    run_op(CRT_OP_LOOP, 1'h0, 1'h0, 3, 3);
    run_op(CRT_OP_LOOP, 1'h1, 1'h0, 4, 4);
    run_op(CRT_OP_STORE_ACC, 1'h0, 1'h0, 5, 8);
    run_op(CRT_OP_STORE_ACC, 1'h0, 1'h1, 5, 12);
    run_op(CRT_OP_LOAD_ACC, 1'h0, 1'h0, 5, 8);
    run_op(CRT_OP_LOAD_ACC, 1'h0, 1'h1, 5, 12);
    run_op(CRT_OP_MOV_IMM_REG, 1'h0, 1'h0, 1, 1);
    run_op(CRT_OP_MOV_REG_RM, 1'h0, 1'h0, 2, 2);
    run_op(CRT_OP_MOV_REG_RM, 1'h1, 1'h0, 5, 20);
    run_op(CRT_OP_MOV_SEG, 1'h0, 1'h0, 2, 2);
    run_op(CRT_OP_MOV_SEG, 1'h1, 1'h0, 5, 20);
    run_op(CRT_OP_RET_NEAR_IMM, 1'h0, 1'h0, 16, 13);
    run_op(CRT_OP_ROL_1, 1'h0, 1'h0, 1, 1);
    run_op(CRT_OP_ROL_1, 1'h1, 1'h0, 8, 16);
    run_op(CRT_OP_ROR_CL, 1'h0, 1'h0, 1, 1);
    run_op(CRT_OP_ROR_CL, 1'h1, 1'h0, 8, 16);
    t_warm(1'h1);
    t_warm(1'h0);
    end_sim();
  end
endmodule
